/* File: fmt_ctrl.sv */
// Format control command and low and high nibble-address write decode
// What this block does
// [RQ1] Format command only in long frame formats
// [RQ2] Broadcast address: execute, send no response
// [RQ3] Command code 1010 selects format command
// [RQ4] Foreign node address: ignore, no response
// [RQ5] Data byte: direction, index, value fields
// [RQ6] Direction one writes value to register
// [RQ7] Direction zero reads, register unchanged
// [RQ8] Response: node address, direction, index echoed
// [RQ9] Write response carries the written value
// [RQ10] Read response carries current register contents
// [RQ11] Response bits 11:8 fixed 0110, CRC follows
// [RQ12] Bank 01 writes low user nibbles
// [RQ13] Bank 10 writes high user nibbles
// [RQ14] Bank 10 location 0111 stores option bit
// [RQ15] Unused location: no write, node address returned
// [RQ16] Program cells only with commit flag set
// [RQ17] Selection 1111 programmed, 0000 standard, else ignored
// [RQ18] CRC length above 8 is discarded
// [RQ19] New format active now, response uses old
`timescale 1ns/10ps
module fmt_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Device identity and mode
  input wire logic [3:0] node_addr_i,
  input wire logic otp_commit_flag_i,
  // Format control command
  input wire logic cmd_valid_i,
  input wire fmt_ctrl_pkg::fmt_cmd_t cmd_i,
  // Non-volatile write command
  input wire logic nvm_valid_i,
  input wire fmt_ctrl_pkg::nvm_cmd_t nvm_i,
  // Response
  output logic resp_valid_o,
  output logic [15:0] resp_data_o,
  output logic [3:0] resp_crc_len_o,
  // Active frame format
  output fmt_ctrl_pkg::fmt_active_t fmt_active_o,
  // Mirror registers and cell programming
  output logic [fmt_ctrl_pkg::NUM_USER-1:0][7:0] user_byte_o,
  output logic option_bit_o,
  output logic otp_prog_o,
  output fmt_ctrl_pkg::nvm_cmd_t otp_cmd_o
);
  import fmt_ctrl_pkg::*;

  logic fmt_hit;
  logic fmt_respond;
  logic fmt_write;
  logic [2:0] format_reg_index;
  logic [3:0] format_reg_value;
  logic [3:0] fmt_rd_val;
  logic [NUM_FMT-1:0][3:0] fmt_reg_val;
  logic nvm_fire;
  logic low_hit;
  logic high_hit;
  logic opt_hit;
  logic mapped;
  logic [2:0] user_idx;
  logic [3:0] nvm_rd;
  logic [NUM_USER-1:0][7:0] user_byte_ff;
  logic option_bit_ff;
  logic resp_valid_ff;
  logic [15:0] resp_data_ff;
  logic [3:0] resp_crc_len_ff;
  logic otp_prog_ff;
  nvm_cmd_t otp_cmd_ff;
  logic [15:0] nxt_resp_data;

  assign format_reg_index = cmd_i.data[IDX_HI:IDX_LO]; // [RQ5]
  assign format_reg_value = cmd_i.data[VAL_HI:0]; // [RQ5]
  assign fmt_hit = cmd_valid_i && cmd_i.code == CMD_FORMAT // [RQ3]
    && (cmd_i.kind == FRAME_STD_LONG || cmd_i.kind == FRAME_ENH_LONG) // [RQ1]
    && (cmd_i.node == node_addr_i || cmd_i.node == BCAST_ADDR); // [RQ4]
  assign fmt_respond = fmt_hit && cmd_i.node != BCAST_ADDR; // [RQ2]
  assign fmt_write = fmt_hit && cmd_i.data[DIR_BIT]; // [RQ6] [RQ7]

  fmt_regs u_fmt_regs (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(fmt_write),
    .idx_i(format_reg_index),
    .val_i(format_reg_value),
    .rd_val_o(fmt_rd_val),
    .reg_val_o(fmt_reg_val),
    .active_o(fmt_active_o)
  );

  // A format command in the same cycle wins over a location write
  assign nvm_fire = nvm_valid_i && !fmt_hit;
  assign low_hit = nvm_i.bank == BANK_LOW_NIB && nvm_i.loc >= LOC_USER_FIRST
    && nvm_i.loc <= LOC_LOW_LAST; // [RQ12]
  assign high_hit = nvm_i.bank == BANK_HIGH_NIB && nvm_i.loc >= LOC_USER_FIRST; // [RQ13]
  assign opt_hit = nvm_i.bank == BANK_HIGH_NIB && nvm_i.loc == LOC_OPTION; // [RQ14]
  assign mapped = low_hit || high_hit || opt_hit; // [RQ15]
  assign user_idx = nvm_i.loc[2:0];

  always_comb begin
    nvm_rd = node_addr_i; // [RQ15]
    if (low_hit || high_hit) begin
      nvm_rd = nvm_i.data;
    end else if (opt_hit) begin
      nvm_rd = {2'h0, nvm_i.data[OPT_DATA_BIT], 1'b0};
    end
    if (fmt_hit) begin
      nxt_resp_data = {node_addr_i, RESP_FIXED, cmd_i.data[DIR_BIT:IDX_LO],
                       fmt_rd_val}; // [RQ8] [RQ9] [RQ10] [RQ11]
    end else if (otp_commit_flag_i) begin
      nxt_resp_data = {node_addr_i, nvm_i.loc, NVM_ON_TAG, nvm_i.bank, nvm_rd};
    end else begin
      nxt_resp_data = {node_addr_i, NVM_OFF_MID, NVM_OFF_TAG, node_addr_i}; // [RQ16]
    end
  end

  // Mirror nibbles follow every mapped write, commit or not
  for (genvar i = 0; i < NUM_USER; i++) begin : g_user
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        user_byte_ff[i] <= 8'h00;
      end else if (nvm_fire && user_idx == 3'(i)) begin
        if (low_hit) begin
          user_byte_ff[i][3:0] <= nvm_i.data; // [RQ12]
        end else if (high_hit) begin
          user_byte_ff[i][7:4] <= nvm_i.data; // [RQ13]
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      option_bit_ff <= 1'b0;
    end else if (nvm_fire && opt_hit) begin
      option_bit_ff <= nvm_i.data[OPT_DATA_BIT]; // [RQ14]
    end
  end

  // Cell programming pulse; unused locations never program
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      otp_prog_ff <= 1'b0;
      otp_cmd_ff <= '0;
    end else begin
      otp_prog_ff <= nvm_fire && mapped && otp_commit_flag_i; // [RQ16] [RQ15]
      if (nvm_fire) begin
        otp_cmd_ff <= nvm_i;
      end
    end
  end

  // CRC length of the frame that carries this response is the old one
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      resp_valid_ff <= 1'b0;
      resp_data_ff <= 16'h0000;
      resp_crc_len_ff <= FMT_STD[IDX_CRC_LEN];
    end else begin
      resp_valid_ff <= fmt_respond || nvm_fire; // [RQ2] [RQ4]
      if (fmt_respond || nvm_fire) begin
        resp_data_ff <= nxt_resp_data;
        resp_crc_len_ff <= fmt_active_o.crc_len; // [RQ19] [RQ11]
      end
    end
  end

  assign resp_valid_o = resp_valid_ff;
  assign resp_data_o = resp_data_ff;
  assign resp_crc_len_o = resp_crc_len_ff;
  assign user_byte_o = user_byte_ff;
  assign option_bit_o = option_bit_ff;
  assign otp_prog_o = otp_prog_ff;
  assign otp_cmd_o = otp_cmd_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_short_discard: assert property ( // [RQ1]
    cmd_valid_i && cmd_i.code == CMD_FORMAT && !nvm_valid_i
    && (cmd_i.kind == FRAME_STD_SHORT || cmd_i.kind == FRAME_ENH_SHORT)
    |=> !resp_valid_o && $stable(fmt_reg_val))
    else $error("format command in short frame acted on");
  a_bcast_silent: assert property ( // [RQ2]
    fmt_hit && cmd_i.node == BCAST_ADDR && !nvm_valid_i |=> !resp_valid_o)
    else $error("broadcast format command answered");
  a_code_decode: assert property ( // [RQ3]
    cmd_valid_i && cmd_i.code != CMD_FORMAT && !nvm_valid_i |=> !resp_valid_o)
    else $error("wrong command code answered");
  a_addr_mismatch: assert property ( // [RQ4]
    cmd_valid_i && cmd_i.node != node_addr_i && cmd_i.node != BCAST_ADDR
    && !nvm_valid_i |=> !resp_valid_o && $stable(fmt_reg_val))
    else $error("foreign address acted on");
  a_resp_layout: assert property ( // [RQ8] [RQ11] [RQ5]
    fmt_respond |=> resp_valid_o && resp_data_o[15:12] == $past(node_addr_i)
    && resp_data_o[11:8] == RESP_FIXED
    && resp_data_o[7:4] == $past(cmd_i.data[DIR_BIT:IDX_LO]))
    else $error("format response layout wrong");
  a_write_echo: assert property ( // [RQ6] [RQ9]
    fmt_respond && cmd_i.data[DIR_BIT] && format_reg_index == IDX_SEED_LO
    |=> resp_data_o[3:0] == $past(format_reg_value)
    && fmt_reg_val[IDX_SEED_LO] == $past(format_reg_value))
    else $error("written value not stored or echoed");
  a_read_stable: assert property ( // [RQ7]
    fmt_hit && !cmd_i.data[DIR_BIT] |=> $stable(fmt_reg_val))
    else $error("read changed a format register");
  a_read_value: assert property ( // [RQ10]
    fmt_respond && !cmd_i.data[DIR_BIT] && format_reg_index != IDX_RSVD
    |=> resp_data_o[3:0] == $past(fmt_reg_val[format_reg_index]))
    else $error("read response contents wrong");
  a_crc_len_guard: assert property ( // [RQ18]
    fmt_write && format_reg_index == IDX_CRC_LEN && format_reg_value > CRC_LEN_MAX
    |=> $stable(fmt_reg_val[IDX_CRC_LEN]))
    else $error("oversize CRC length stored");
  a_sel_source: assert property ( // [RQ17]
    ##1 fmt_active_o.crc_len == ((fmt_reg_val[IDX_SEL] == SEL_ON)
    ? fmt_reg_val[IDX_CRC_LEN] : FMT_STD[IDX_CRC_LEN]))
    else $error("active format does not follow selection");
  a_prev_format: assert property ( // [RQ19]
    fmt_respond |=> resp_crc_len_o == $past(fmt_active_o.crc_len))
    else $error("response did not keep previous format");
  a_low_nibble: assert property ( // [RQ12]
    nvm_fire && low_hit |=> user_byte_o[$past(user_idx)][3:0] == $past(nvm_i.data))
    else $error("low user nibble not written");
  a_high_nibble: assert property ( // [RQ13]
    nvm_fire && high_hit |=> user_byte_o[$past(user_idx)][7:4] == $past(nvm_i.data))
    else $error("high user nibble not written");
  a_option_bit: assert property ( // [RQ14]
    nvm_fire && opt_hit |=> option_bit_o == $past(nvm_i.data[OPT_DATA_BIT]))
    else $error("option bit not stored");
  a_unused_loc: assert property ( // [RQ15]
    nvm_fire && !mapped |=> !otp_prog_o && resp_data_o[3:0] == $past(node_addr_i)
    && $stable(user_byte_o))
    else $error("unused location acted on");
  a_commit_gate: assert property ( // [RQ16]
    nvm_fire && !otp_commit_flag_i |=> !otp_prog_o
    && resp_data_o == {$past(node_addr_i), NVM_OFF_MID, NVM_OFF_TAG, $past(node_addr_i)})
    else $error("cells programmed without commit");

  c_fmt_write: cover property (fmt_respond && cmd_i.data[DIR_BIT] ##1 resp_valid_o);
  c_sel_on: cover property (fmt_write && format_reg_index == IDX_SEL
    && format_reg_value == SEL_ON);
  c_nvm_commit: cover property (nvm_fire && mapped && otp_commit_flag_i ##1 otp_prog_o);
  c_bcast: cover property (fmt_hit && cmd_i.node == BCAST_ADDR);
endmodule // fmt_ctrl

/* File: fmt_ctrl_pkg.sv */
// Shared constants and types plus the format control register file
package fmt_ctrl_pkg;
  localparam logic [3:0] CMD_FORMAT = 4'hA;
  localparam logic [3:0] BCAST_ADDR = 4'h0;
  localparam logic [3:0] RESP_FIXED = 4'h6;
  localparam logic [3:0] NVM_OFF_MID = 4'h0;
  localparam logic [3:0] NVM_OFF_TAG = 4'hF;
  localparam logic [1:0] NVM_ON_TAG = 2'h3;
  localparam int DIR_BIT = 7;
  localparam int IDX_HI = 6;
  localparam int IDX_LO = 4;
  localparam int VAL_HI = 3;
  localparam int NUM_FMT = 8;
  localparam int NUM_USER = 8;
  localparam logic [2:0] IDX_POLY_LO = 3'h0;
  localparam logic [2:0] IDX_POLY_HI = 3'h1;
  localparam logic [2:0] IDX_SEED_LO = 3'h2;
  localparam logic [2:0] IDX_SEED_HI = 3'h3;
  localparam logic [2:0] IDX_CRC_LEN = 3'h4;
  localparam logic [2:0] IDX_SHORT_LEN = 3'h5;
  localparam logic [2:0] IDX_RSVD = 3'h6;
  localparam logic [2:0] IDX_SEL = 3'h7;
  // Reset and standard frame values, index 7 down to 0
  localparam logic [NUM_FMT-1:0][3:0] FMT_STD =
    {4'h0, 4'h0, 4'h8, 4'h4, 4'h0, 4'hA, 4'h1, 4'h1};
  localparam logic [3:0] CRC_LEN_MAX = 4'h8;
  localparam logic [3:0] SHORT_LEN_MIN = 4'h8;
  localparam logic [3:0] SEL_ON = 4'hF;
  localparam logic [3:0] SEL_OFF = 4'h0;
  localparam logic [3:0] RSVD_READ = 4'h0;
  localparam logic [1:0] BANK_LOW_NIB = 2'h1;
  localparam logic [1:0] BANK_HIGH_NIB = 2'h2;
  localparam logic [3:0] LOC_USER_FIRST = 4'h8;
  localparam logic [3:0] LOC_LOW_LAST = 4'hE;
  localparam logic [3:0] LOC_OPTION = 4'h7;
  localparam int OPT_DATA_BIT = 1;

  typedef enum logic [1:0] {
    FRAME_STD_LONG,
    FRAME_ENH_LONG,
    FRAME_STD_SHORT,
    FRAME_ENH_SHORT
  } frame_kind_t;

  typedef struct packed {
    frame_kind_t kind;
    logic [3:0] code;
    logic [3:0] node;
    logic [7:0] data;
  } fmt_cmd_t;

  typedef struct packed {
    logic [1:0] bank;
    logic [3:0] loc;
    logic [3:0] data;
  } nvm_cmd_t;

  typedef struct packed {
    logic [7:0] poly;
    logic [7:0] seed;
    logic [3:0] crc_len;
    logic [3:0] short_len;
  } fmt_active_t;
endpackage

`timescale 1ns/10ps
module fmt_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Access
  input wire logic wr_en_i,
  input wire logic [2:0] idx_i,
  input wire logic [3:0] val_i,
  output logic [3:0] rd_val_o,
  // State
  output logic [fmt_ctrl_pkg::NUM_FMT-1:0][3:0] reg_val_o,
  output fmt_ctrl_pkg::fmt_active_t active_o
);
  import fmt_ctrl_pkg::*;

  logic [NUM_FMT-1:0][3:0] reg_ff;
  logic [NUM_FMT-1:0][3:0] nxt_reg;
  logic [NUM_FMT-1:0][3:0] nxt_src;
  logic accept;

  always_comb begin
    accept = wr_en_i;
    if (idx_i == IDX_CRC_LEN && val_i > CRC_LEN_MAX) begin // [RQ18]
      accept = 1'b0;
    end
    if (idx_i == IDX_SHORT_LEN && val_i < SHORT_LEN_MIN) begin
      accept = 1'b0;
    end
    if (idx_i == IDX_SEL && val_i != SEL_ON && val_i != SEL_OFF) begin // [RQ17]
      accept = 1'b0;
    end
    if (idx_i == IDX_RSVD) begin
      accept = 1'b0;
    end
    nxt_reg = reg_ff;
    if (accept) begin
      nxt_reg[idx_i] = val_i; // [RQ6]
    end
    // Selection on picks programmed values, off the standard ones
    nxt_src = (nxt_reg[IDX_SEL] == SEL_ON) ? nxt_reg : FMT_STD; // [RQ17]
  end

  // Value after the access: the written value on an accepted write, else the contents
  assign rd_val_o = (idx_i == IDX_RSVD) ? RSVD_READ : nxt_reg[idx_i]; // [RQ9] [RQ10]
  assign reg_val_o = reg_ff;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_ff <= FMT_STD;
    end else begin
      reg_ff <= nxt_reg;
    end
  end

  // Active set follows the same edge as the write
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      active_o <= '{poly: {FMT_STD[IDX_POLY_HI], FMT_STD[IDX_POLY_LO]},
                    seed: {FMT_STD[IDX_SEED_HI], FMT_STD[IDX_SEED_LO]},
                    crc_len: FMT_STD[IDX_CRC_LEN],
                    short_len: FMT_STD[IDX_SHORT_LEN]};
    end else begin
      active_o <= '{poly: {nxt_src[IDX_POLY_HI], nxt_src[IDX_POLY_LO]},
                    seed: {nxt_src[IDX_SEED_HI], nxt_src[IDX_SEED_LO]},
                    crc_len: nxt_src[IDX_CRC_LEN],
                    short_len: nxt_src[IDX_SHORT_LEN]}; // [RQ19]
    end
  end
endmodule // fmt_regs

/* File: bus_master_model.sv */
// Bus master model that issues format and location-write commands
`timescale 1ns/10ps
module bus_master_model
  import fmt_ctrl_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Format command
  output logic cmd_valid_o,
  output fmt_ctrl_pkg::fmt_cmd_t cmd_o,
  // Location write
  output logic nvm_valid_o,
  output fmt_ctrl_pkg::nvm_cmd_t nvm_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
    nvm_valid_o = 1'b0;
    nvm_o = '0;
  end

  // One-cycle strobe; lines flip on release so stale data never looks valid
  task automatic send_fmt(input frame_kind_t kind, input logic [3:0] code,
                          input logic [3:0] node, input logic [7:0] data);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_o <= '{kind: kind, code: code, node: node, data: data};
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_o <= fmt_cmd_t'(~cmd_o);
    #1;
  endtask

  task automatic send_nvm(input logic [1:0] bank, input logic [3:0] loc,
                          input logic [3:0] data);
    @(posedge clk_i);
    nvm_valid_o <= 1'b1;
    nvm_o <= '{bank: bank, loc: loc, data: data};
    @(posedge clk_i);
    nvm_valid_o <= 1'b0;
    nvm_o <= nvm_cmd_t'(~nvm_o);
    #1;
  endtask
endmodule // bus_master_model

/* File: test_fmt_ctrl.sv */
// Self-checking testbench for the format control block
`timescale 1ns/10ps
module test_fmt_ctrl;
  import fmt_ctrl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0] node_addr_i = 4'h5;
  logic otp_commit_flag_i = 1'b1;
  logic cmd_valid_i;
  fmt_cmd_t cmd_i;
  logic nvm_valid_i;
  nvm_cmd_t nvm_i;
  logic resp_valid_o;
  logic [15:0] resp_data_o;
  logic [3:0] resp_crc_len_o;
  fmt_active_t fmt_active_o;
  logic [NUM_USER-1:0][7:0] user_byte_o;
  logic option_bit_o;
  logic otp_prog_o;
  nvm_cmd_t otp_cmd_o;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [3:0] std_val [8] = '{4'h1, 4'h1, 4'hA, 4'h0, 4'h4, 4'h8, 4'h0, 4'h0};
  logic [NUM_USER-1:0][7:0] ub = '0;
  localparam logic [23:0] STD_ACTIVE = {8'h11, 8'h0A, 4'h4, 4'h8};

  always #5 clk_i = ~clk_i;

  bus_master_model bus_master_model_inst (.clk_i(clk_i), .cmd_valid_o(cmd_valid_i),
    .cmd_o(cmd_i), .nvm_valid_o(nvm_valid_i), .nvm_o(nvm_i));

  fmt_ctrl fmt_ctrl_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .node_addr_i(node_addr_i),
    .otp_commit_flag_i(otp_commit_flag_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .nvm_valid_i(nvm_valid_i), .nvm_i(nvm_i), .resp_valid_o(resp_valid_o),
    .resp_data_o(resp_data_o), .resp_crc_len_o(resp_crc_len_o),
    .fmt_active_o(fmt_active_o), .user_byte_o(user_byte_o), .option_bit_o(option_bit_o),
    .otp_prog_o(otp_prog_o), .otp_cmd_o(otp_cmd_o));

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard, well above the hundred or so cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      final_report();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Accepted format command and its response word
  task automatic fmt(input frame_kind_t kind, input logic dir, input logic [2:0] idx,
                     input logic [3:0] val, input logic [3:0] exp_val, input logic [3:0] crc);
    bus_master_model_inst.send_fmt(kind, 4'hA, node_addr_i, {dir, idx, val});
    chk(resp_valid_o, 1'b1);
    chk(resp_data_o, {node_addr_i, 4'h6, dir, idx, exp_val});
    chk(resp_crc_len_o, crc);
  endtask

  task automatic silent(input frame_kind_t kind, input logic [3:0] code,
                        input logic [3:0] node);
    bus_master_model_inst.send_fmt(kind, code, node, {1'b1, IDX_CRC_LEN, 4'h2});
    chk(resp_valid_o, 1'b0);
  endtask

  task automatic nvm(input logic [1:0] bank, input logic [3:0] loc, input logic [3:0] data,
                     input logic [15:0] exp_word, input logic exp_prog);
    bus_master_model_inst.send_nvm(bank, loc, data);
    chk(resp_valid_o, 1'b1);
    chk(resp_data_o, exp_word);
    chk(otp_prog_o, exp_prog);
    chk(otp_cmd_o, {bank, loc, data});
  endtask

  task automatic t_reset();
    chk(fmt_active_o, STD_ACTIVE);
    chk(resp_valid_o, 1'b0);
    for (int i = 0; i < 8; i++) begin
      fmt(FRAME_STD_LONG, 1'b0, 3'(i), 4'hF, std_val[i], 4'h4);
    end
  endtask

  task automatic t_write();
    fmt(FRAME_ENH_LONG, 1'b1, IDX_POLY_LO, 4'h3, 4'h3, 4'h4);
    chk(fmt_active_o.poly, 8'h11);
    fmt(FRAME_ENH_LONG, 1'b1, IDX_SEED_LO, 4'h5, 4'h5, 4'h4);
    fmt(FRAME_STD_LONG, 1'b1, IDX_SEL, 4'hF, 4'hF, 4'h4);
    chk(fmt_active_o.poly, 8'h13);
    chk(fmt_active_o.seed, 8'h05);
    fmt(FRAME_STD_LONG, 1'b1, IDX_CRC_LEN, 4'h8, 4'h8, 4'h4);
    chk(fmt_active_o.crc_len, 4'h8);
    fmt(FRAME_STD_LONG, 1'b1, IDX_CRC_LEN, 4'h9, 4'h8, 4'h8);
    fmt(FRAME_STD_LONG, 1'b0, IDX_CRC_LEN, 4'h1, 4'h8, 4'h8);
    fmt(FRAME_STD_LONG, 1'b1, IDX_SEL, 4'h5, 4'hF, 4'h8);
    chk(fmt_active_o.crc_len, 4'h8);
    fmt(FRAME_STD_LONG, 1'b1, IDX_SEL, 4'h0, 4'h0, 4'h8);
    chk(fmt_active_o, STD_ACTIVE);
    fmt(FRAME_STD_LONG, 1'b0, IDX_POLY_LO, 4'h0, 4'h3, 4'h4);
  endtask

  // Every refused case tries a write, so any leak shows on read-back
  task automatic t_refuse();
    silent(FRAME_STD_SHORT, 4'hA, node_addr_i);
    silent(FRAME_ENH_SHORT, 4'hA, node_addr_i);
    silent(FRAME_STD_LONG, 4'hB, node_addr_i);
    silent(FRAME_STD_LONG, 4'h9, node_addr_i);
    silent(FRAME_ENH_LONG, 4'hA, 4'h6);
    fmt(FRAME_STD_LONG, 1'b0, IDX_CRC_LEN, 4'h0, 4'h8, 4'h4);
    silent(FRAME_STD_LONG, 4'hA, 4'h0);
    fmt(FRAME_STD_LONG, 1'b0, IDX_CRC_LEN, 4'h0, 4'h2, 4'h4);
    // Short length below 8 is kept out like an oversize CRC length
    fmt(FRAME_STD_LONG, 1'b1, IDX_SHORT_LEN, 4'h7, 4'h8, 4'h4);
  endtask

  task automatic t_nvm();
    for (int i = 0; i < 7; i++) begin
      ub[i][3:0] = 4'(i + 1);
      nvm(BANK_LOW_NIB, 4'(8 + i), 4'(i + 1),
          {node_addr_i, 4'(8 + i), 2'b11, 2'b01, 4'(i + 1)}, 1'b1);
    end
    for (int i = 0; i < 8; i++) begin
      ub[i][7:4] = 4'(15 - i);
      nvm(BANK_HIGH_NIB, 4'(8 + i), 4'(15 - i),
          {node_addr_i, 4'(8 + i), 2'b11, 2'b10, 4'(15 - i)}, 1'b1);
    end
    chk(user_byte_o, ub);
    nvm(BANK_HIGH_NIB, 4'h7, 4'hD, {node_addr_i, 4'h7, 2'b11, 2'b10, 4'h0}, 1'b1);
    chk(option_bit_o, 1'b0);
    nvm(BANK_HIGH_NIB, 4'h7, 4'h2, {node_addr_i, 4'h7, 2'b11, 2'b10, 4'h2}, 1'b1);
    chk(option_bit_o, 1'b1);
    nvm(BANK_LOW_NIB, 4'hF, 4'h9, {node_addr_i, 4'hF, 2'b11, 2'b01, node_addr_i}, 1'b0);
    nvm(2'h3, 4'hA, 4'h9, {node_addr_i, 4'hA, 2'b11, 2'b11, node_addr_i}, 1'b0);
    chk(user_byte_o, ub);
    @(posedge clk_i);
    otp_commit_flag_i <= 1'b0;
    ub[0][3:0] = 4'hC;
    nvm(BANK_LOW_NIB, 4'h8, 4'hC, {node_addr_i, 4'h0, 4'hF, node_addr_i}, 1'b0);
    chk(user_byte_o, ub);
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_write();
    t_refuse();
    t_nvm();
    repeat (2) @(posedge clk_i);
    final_report();
  end
endmodule // test_fmt_ctrl
